// File: cmh_ctrl.sv
// Notes on behaviour
// - Hold codec reset 50 ms at power-up or after power-down, else 100 ns.
// - Handshake bit sits at word bit 58 and passes bus ownership.
// - Caller should ramp audio down before control mode is entered.
// - Controller waits four periods before clocking when codec was master.
// - Codec master with external timing: controller may clock at once.
// - Controller clocks four periods first; chain input stays low until word.
// - Codec slave: controller keeps clocking, chain input after four periods.
// - Send words with handshake bit clear until echo reads zero.
// - With external clock source, hold selection 2 ms before raising select.
// - Never set handshake bit before the zero echo arrives.
// - Supply at least 65 bit clocks for the final word.
`timescale 1ns/1ps
`default_nettype none
`include "cmh_defs.svh"

module cmh_ctrl
   import cmh_pkg::*;
#(
   parameter int unsigned RST_LONG_CYC = `CMH_RST_LONG_CYC,
   parameter int unsigned STABLE_CYC   = `CMH_STABLE_CYC
) (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        start_i,
   input  wire logic [63:0] cfg_word_i,
   input  wire logic        dev_master_i,
   input  wire logic        ext_src_i,
   input  wire logic        power_down_i,
   input  wire logic        reset_req_i,
   input  wire logic        serial_tx_line_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [63:0]      echo_word_o,
   output logic             codec_rst_n_o,
   output logic             power_down_input_o,
   output logic             data_control_select_o,
   output logic             sclk_o,
   output logic             sclk_oe_o,
   output logic             word_chain_in_o,
   output logic             serial_rx_line_o
);

   cmh_regs_t   s;
   cmh_regs_t   nxt;
   logic        sc_rise;
   logic        sc_fall;
   logic [63:0] new_echo;
   logic        frame_end;
   logic [31:0] rst_lim;

   cmh_sclk_div #(
      .HALF(`CMH_SCLK_HALF)
   ) u_div (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i    (s.oe),
      .sclk_o   (sclk_o),
      .rise_o   (sc_rise),
      .fall_o   (sc_fall)
   );

   always_comb begin
      nxt        = s;
      new_echo   = {s.rx_shift[62:0], s.serial_tx_line_s};
      frame_end  = 1'b0;
      rst_lim    = s.long_rst ? 32'(RST_LONG_CYC) : 32'(`CMH_RST_SHORT_CYC);
      nxt.done   = 1'b0;
      nxt.power_down_input    = power_down_i;
      nxt.serial_tx_line_m = serial_tx_line_i;
      nxt.serial_tx_line_s = s.serial_tx_line_m;
      // Bit engine: drive on rise, sample echo on fall, one word per frame
      if (s.st == CMH_SEND0 || s.st == CMH_SEND1) begin
         if (sc_rise) begin
            nxt.serial_rx_line = s.tx_word[6'd63 - s.bit_idx];
            nxt.word_chain_in = (s.bit_idx == 6'd0);
         end
         if (sc_fall) begin
            nxt.rx_shift = new_echo;
            nxt.bit_idx  = s.bit_idx + 6'd1;
            frame_end    = (s.bit_idx == 6'd63);
         end
      end
      unique case (s.st)
         CMH_RESET: begin
            nxt.rst_n = 1'b0;
            nxt.dcs   = 1'b0;
            if (s.cnt + 32'd1 >= rst_lim) begin
               nxt.st         = CMH_IDLE;
               nxt.rst_n      = 1'b1;
               nxt.long_rst   = 1'b0;
               nxt.cnt        = '0;
               nxt.dev_master = 1'b0;
            end else begin
               nxt.cnt = s.cnt + 32'd1;
            end
         end
         CMH_IDLE: begin
            // Caller is expected to have ramped the volume down by now
            if (start_i) begin
               nxt.tx_word    = {cfg_word_i[63:59], 1'b0, cfg_word_i[57:0]};
               nxt.dev_master = s.dcs & dev_master_i;
               nxt.ext_src    = ext_src_i;
               nxt.dcs        = 1'b0;
               nxt.cnt        = '0;
               nxt.st         = CMH_ENTER;
            end
         end
         CMH_ENTER: begin
            nxt.word_chain_in = 1'b0;
            if (s.cnt + 32'd1 >= 32'(`CMH_ENTER_CYC)) begin
               nxt.st          = CMH_SEND0;
               nxt.cnt         = '0;
               nxt.bit_idx     = 6'd0;
               nxt.first_frame = 1'b1;
            end else begin
               nxt.cnt = s.cnt + 32'd1;
            end
         end
         CMH_SEND0: begin
            if (frame_end) begin
               nxt.echo        = new_echo;
               nxt.first_frame = 1'b0;
               // Bit flips only at a word boundary, so no glitch can reach the codec
               if (!s.first_frame && !new_echo[`CMH_BIT_DCB]) begin
                  nxt.st                   = CMH_SEND1;
                  nxt.tx_word[`CMH_BIT_DCB] = 1'b1;
                  nxt.first_frame          = 1'b1;
               end
            end
         end
         CMH_SEND1: begin
            if (frame_end) begin
               nxt.echo        = new_echo;
               nxt.first_frame = 1'b0;
               // First echo here still reflects the last zero word
               if (!s.first_frame && new_echo[`CMH_BIT_DCB]) begin
                  nxt.st   = CMH_TAIL;
                  nxt.cnt  = '0;
                  nxt.word_chain_in = 1'b0;
                  nxt.serial_rx_line = 1'b0;
               end
            end
         end
         CMH_TAIL: begin
            if (sc_rise) begin
               if (s.cnt + 32'd1 >= 32'(`CMH_TAIL_BITS)) begin
                  nxt.st  = CMH_HOLD;
                  nxt.cnt = '0;
               end else begin
                  nxt.cnt = s.cnt + 32'd1;
               end
            end
         end
         CMH_HOLD: begin
            if (!s.ext_src || s.cnt + 32'd1 >= 32'(STABLE_CYC)) begin
               nxt.st   = CMH_IDLE;
               nxt.dcs  = 1'b1;
               nxt.done = 1'b1;
               nxt.its  = s.tx_word[`CMH_BIT_ITS];
               nxt.cnt  = '0;
            end else begin
               nxt.cnt = s.cnt + 32'd1;
            end
         end
         default: begin
            nxt.st = CMH_RESET;
         end
      endcase
      // Leaving power-down always needs the long reset
      if (power_down_i) begin
         nxt.st       = CMH_RESET;
         nxt.long_rst = 1'b1;
         nxt.cnt      = '0;
         nxt.rst_n    = 1'b0;
         nxt.dcs      = 1'b0;
      end else if (reset_req_i && s.st != CMH_RESET) begin
         nxt.st    = CMH_RESET;
         nxt.cnt   = '0;
         nxt.rst_n = 1'b0;
         nxt.dcs   = 1'b0;
      end
      // Codec mastering with internal timing owns the clock for a while
      nxt.oe = (nxt.st inside {CMH_SEND0, CMH_SEND1, CMH_TAIL, CMH_HOLD})
             || (nxt.st == CMH_ENTER && (!nxt.dev_master || nxt.its))
             || (nxt.st == CMH_IDLE && nxt.dcs && !nxt.dev_master);
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         s          <= '0;
         s.st       <= CMH_RESET;
         s.long_rst <= 1'b1;
      end else begin
         s <= nxt;
      end
   end

   assign busy_o                = (s.st != CMH_IDLE);
   assign done_o                = s.done;
   assign echo_word_o           = s.echo;
   assign codec_rst_n_o         = s.rst_n;
   assign power_down_input_o    = s.power_down_input;
   assign data_control_select_o = s.dcs;
   assign sclk_oe_o             = s.oe;
   assign word_chain_in_o       = s.word_chain_in;
   assign serial_rx_line_o      = s.serial_rx_line;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_rst_hold_len: assert property ($rose(codec_rst_n_o) |->
      $past(s.cnt) + 32'd1 >= 32'(`CMH_RST_SHORT_CYC)) else $error("codec reset too short");
   a_pdn_long_rst: assert property ($fell(power_down_input_o) |->
      !codec_rst_n_o ##1 !codec_rst_n_o) else $error("reset released early after power-down");
   a_master_quiet: assert property ((s.st == CMH_ENTER && s.dev_master && !s.its)
      |-> !sclk_oe_o) else $error("clock driven while codec still masters it");
   a_enter_wait: assert property ($rose(s.st == CMH_SEND0) |->
      $past(s.cnt) + 32'd1 == 32'(`CMH_ENTER_CYC) && !word_chain_in_o)
      else $error("word chain input issued too early");
   a_zero_before_one: assert property ((s.st == CMH_SEND0) |->
      !s.tx_word[`CMH_BIT_DCB]) else $error("handshake bit set before zero echo");
   a_first_lock: assert property ((s.st == CMH_SEND1 && $past(s.st) == CMH_SEND0) |->
      !s.echo[`CMH_BIT_DCB] && s.tx_word[`CMH_BIT_DCB]) else $error("interlock one skipped");
   a_second_lock: assert property ((s.st == CMH_TAIL && $past(s.st) == CMH_SEND1) |->
      s.echo[`CMH_BIT_DCB] && !word_chain_in_o) else $error("interlock two skipped");
   a_tail_clocks: assert property ($rose(s.st == CMH_HOLD) |->
      $past(s.cnt) + 32'd1 == 32'(`CMH_TAIL_BITS) && sclk_oe_o)
      else $error("too few trailing bit clocks");
   a_ext_stable: assert property (($rose(data_control_select_o) && s.ext_src) |->
      $past(s.cnt) + 32'd1 >= 32'(STABLE_CYC)) else $error("select raised before 2 ms");
   a_word_chain_in_width: assert property ($rose(word_chain_in_o) |->
      word_chain_in_o[*8] ##1 !word_chain_in_o) else $error("chain pulse not one bit long");

   c_lock_one: cover property ($rose(s.st == CMH_SEND1));
   c_to_data:  cover property ($rose(data_control_select_o));
   c_pdn:      cover property ($rose(power_down_input_o));
   c_master:   cover property ($rose(s.st == CMH_ENTER) && s.dev_master);

endmodule

`default_nettype wire

// File: cmh_defs.svh
`ifndef CMH_DEFS_SVH
`define CMH_DEFS_SVH

// Own clock rate and link bit clock shape
`define CMH_CLK_KHZ       40000
`define CMH_SCLK_HALF     4

// Control word layout
`define CMH_WORD_BITS     64
`define CMH_BIT_DCB       58
`define CMH_BIT_ITS       47

// Handover timing, in bit clock periods
`define CMH_ENTER_PERIODS 3
`define CMH_TAIL_BITS     2

// Timing in printed units
`define CMH_RST_LONG_MS   50
`define CMH_RST_SHORT_NS  100
`define CMH_STABLE_MS     2

// Derived cycle counts (least times round up)
`define CMH_RST_LONG_CYC  (`CMH_RST_LONG_MS * `CMH_CLK_KHZ)
`define CMH_RST_SHORT_CYC ((`CMH_RST_SHORT_NS * `CMH_CLK_KHZ + 999999) / 1000000)
`define CMH_STABLE_CYC    (`CMH_STABLE_MS * `CMH_CLK_KHZ)
`define CMH_ENTER_CYC     ((`CMH_ENTER_PERIODS + 1) * 2 * `CMH_SCLK_HALF)

`endif

// File: cmh_pkg.sv
package cmh_pkg;

   typedef enum logic [6:0] {
      CMH_RESET = 7'h01,
      CMH_IDLE  = 7'h02,
      CMH_ENTER = 7'h04,
      CMH_SEND0 = 7'h08,
      CMH_SEND1 = 7'h10,
      CMH_TAIL  = 7'h20,
      CMH_HOLD  = 7'h40
   } cmh_state_t;

   typedef struct packed {
      cmh_state_t  st;
      logic [31:0] cnt;
      logic        long_rst;
      logic [5:0]  bit_idx;
      logic [63:0] tx_word;
      logic [63:0] rx_shift;
      logic [63:0] echo;
      logic        first_frame;
      logic        dcs;
      logic        rst_n;
      logic        power_down_input;
      logic        serial_tx_line_m;
      logic        serial_tx_line_s;
      logic        word_chain_in;
      logic        serial_rx_line;
      logic        oe;
      logic        done;
      logic        dev_master;
      logic        its;
      logic        ext_src;
   } cmh_regs_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic       sclk;
      logic       rise;
      logic       fall;
   } cmh_div_t;

endpackage

// File: cmh_sclk_div.sv
`timescale 1ns/1ps
`default_nettype none

module cmh_sclk_div
   import cmh_pkg::*;
#(
   parameter int unsigned HALF = 4
) (
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic run_i,
   output logic      sclk_o,
   output logic      rise_o,
   output logic      fall_o
);

   cmh_div_t s;
   cmh_div_t nxt;

   // Clock restarts low so the first edge after a start is always a rise
   always_comb begin
      nxt      = s;
      nxt.rise = 1'b0;
      nxt.fall = 1'b0;
      if (!run_i) begin
         nxt.cnt  = 8'h00;
         nxt.sclk = 1'b0;
      end else if (s.cnt == 8'(HALF - 1)) begin
         nxt.cnt  = 8'h00;
         nxt.sclk = ~s.sclk;
         nxt.rise = ~s.sclk;
         nxt.fall = s.sclk;
      end else begin
         nxt.cnt = s.cnt + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= nxt;
      end
   end

   assign sclk_o = s.sclk;
   assign rise_o = s.rise;
   assign fall_o = s.fall;

endmodule

`default_nettype wire

// File: cmh_codec_model.sv
`timescale 1ns/1ps
`default_nettype none

module cmh_codec_model #(
   parameter logic [63:0] DEF = 64'h2000_0000_0000_0000
) (
   input  wire logic        codec_rst_n_i,
   input  wire logic        pdn_i,
   input  wire logic        dcs_i,
   input  wire logic        sclk_i,
   input  wire logic        word_chain_in_i,
   input  wire logic        serial_rx_line_i,
   input  wire logic [3:0]  slow_i,
   output logic             serial_tx_line_o,
   output logic [63:0]      last_rx_o
);
   logic [63:0] rx_sr;
   logic [63:0] out_w;
   logic [63:0] regs;
   logic        seen0;
   logic        locked;
   logic        active;
   int          k;
   int          wait_n;

   assign active = codec_rst_n_i && !pdn_i && !dcs_i;

   initial begin
      k = 64;
      serial_tx_line_o = 1'b0;
      regs = DEF;
      last_rx_o = 64'h0000_0000_0000_0000;
   end

   always @(posedge active) begin
      k = 64;
      seen0 = 1'b0;
      locked = 1'b0;
      wait_n = int'(slow_i);
      out_w = regs | 64'h0400_0000_0000_0000;
   end

   // Leaving control mode keeps the programmed word; reset brings back defaults
   always @(negedge active or negedge codec_rst_n_i or posedge pdn_i) begin
      if (!codec_rst_n_i || pdn_i) begin
         regs = DEF;
      end else if (locked) begin
         regs = out_w;
      end
   end

   // A released line toggles so a stale bit can never look valid
   // Chain input is read once the controller's registered update has settled
   always @(posedge sclk_i) begin
      #30;
      if (word_chain_in_i) begin
         k = 0;
      end else if (k < 64) begin
         k = k + 1;
      end
      if (active && k < 64) begin
         serial_tx_line_o = out_w[63-k];
      end else begin
         serial_tx_line_o = ~serial_tx_line_o;
      end
   end

   always @(negedge sclk_i) begin
      if (active && k < 64) begin
         rx_sr[63-k] = serial_rx_line_i;
         if (k == 63 && !locked) begin
            last_rx_o = rx_sr;
            if (!rx_sr[58] && wait_n > 0) begin
               wait_n = wait_n - 1;
               out_w = rx_sr | 64'h0400_0000_0000_0000;
            end else begin
               out_w = rx_sr;
               locked = rx_sr[58] && seen0;
               seen0 = seen0 || !rx_sr[58];
            end
         end
      end
   end
endmodule

`default_nettype wire

// File: codec_mode_handshake_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module codec_mode_handshake_control_tb;
   import cmh_pkg::*;

   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        start = 1'b0;
   logic [63:0] cfg = 64'h0000_0000_0000_0000;
   logic        master = 1'b0;
   logic        ext = 1'b0;
   logic        power_down_input = 1'b0;
   logic        rreq = 1'b0;
   logic [3:0]  slow = 4'h0;
   logic        serial_tx_line;
   logic        busy;
   logic        done;
   logic [63:0] echo;
   logic        rst_n;
   logic        pdn_pin;
   logic        dcs;
   logic        sclk;
   logic        sclk_oe;
   logic        word_chain_in;
   logic        serial_rx_line;
   logic [63:0] last_rx;
   int          miscompares = 0;
   int          n_tests = 0;
   int          cyc = 0;

   always #12.5 ref_clk = ~ref_clk;

   cmh_ctrl #(.RST_LONG_CYC(50), .STABLE_CYC(20)) u_cmh_ctrl (
      .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .start_i(start), .cfg_word_i(cfg),
      .dev_master_i(master), .ext_src_i(ext), .power_down_i(power_down_input), .reset_req_i(rreq),
      .serial_tx_line_i(serial_tx_line), .busy_o(busy), .done_o(done), .echo_word_o(echo),
      .codec_rst_n_o(rst_n), .power_down_input_o(pdn_pin), .data_control_select_o(dcs),
      .sclk_o(sclk), .sclk_oe_o(sclk_oe), .word_chain_in_o(word_chain_in), .serial_rx_line_o(serial_rx_line));

   // Undriven bit clock rests low, like the pull-down on the board
   cmh_codec_model u_cmh_codec_model (
      .codec_rst_n_i(rst_n), .pdn_i(pdn_pin), .dcs_i(dcs), .sclk_i(sclk_oe & sclk),
      .word_chain_in_i(word_chain_in), .serial_rx_line_i(serial_rx_line), .slow_i(slow), .serial_tx_line_o(serial_tx_line), .last_rx_o(last_rx));

   task automatic close_out();
      $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         close_out();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Counts cycles until the codec reset pin returns high
   task automatic rst_len(input int least);
      int n;
      n = 0;
      while (rst_n !== 1'b1 && n < 5000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk({63'h0, n >= least}, 64'h1);
   endtask

   task automatic t_reset();
      #1;
      chk({63'h0, rst_n}, 64'h0);
      rst_len(50);
      chk({63'h0, dcs}, 64'h0);
   endtask

   task automatic t_hs(input logic [63:0] w, input logic m, input logic e, input logic [3:0] s,
                       input logic oe);
      int i;
      while (busy !== 1'b0) @(posedge ref_clk);
      @(posedge ref_clk);
      slow <= s;
      cfg <= w;
      master <= m;
      ext <= e;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      #1;
      chk({62'h0, busy, sclk_oe}, {62'h0, 1'b1, oe});
      chk({63'h0, dcs}, 64'h0);
      for (i = 0; i < 12000 && done !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      chk({63'h0, dcs}, 64'h1);
      chk(echo, w | 64'h0400_0000_0000_0000);
      chk(last_rx, w | 64'h0400_0000_0000_0000);
   endtask

   task automatic t_short();
      @(posedge ref_clk);
      rreq <= 1'b1;
      @(posedge ref_clk);
      rreq <= 1'b0;
      #1;
      rst_len(4);
   endtask

   task automatic t_pdn();
      @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (600) @(posedge ref_clk);
      power_down_input <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk({61'h0, pdn_pin, rst_n, busy}, 64'h5);
      @(posedge ref_clk);
      power_down_input <= 1'b0;
      rst_len(50);
      chk({63'h0, dcs}, 64'h0);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_hs(64'h2000_1234_5678_9abc, 1'b0, 1'b0, 4'h0, 1'b1);
      t_hs(64'h2000_8a5a_0000_0f0f, 1'b1, 1'b1, 4'h2, 1'b0);
      t_hs(64'h2000_0005_c3c3_0000, 1'b1, 1'b0, 4'h0, 1'b1);
      t_short();
      t_pdn();
      close_out();
   end
endmodule

`default_nettype wire
